// >>> verilog/ldo_pkg.sv
`default_nettype none
package ldo_pkg;
	localparam int ADDR_W = 12;

	// register indices inside each logical-device bank
	localparam logic [7:0] IDX_MODE   = 8'hf0;
	localparam logic [7:0] IDX_OPTION = 8'hf1;
	localparam logic [7:0] IDX_TYPES  = 8'hf2;
	localparam logic [7:0] IDX_ZERO   = 8'hf3;
	localparam logic [7:0] IDX_DRV0   = 8'hf4;
	localparam logic [7:0] IDX_DRV1   = 8'hf5;

	// bank selects, paddr[11:10]; byte address = bank base + 4 * index
	localparam logic [1:0] BANK_FLOPPY = 2'h0;
	localparam logic [1:0] BANK_PRINT  = 2'h1;
	localparam logic [1:0] BANK_SERIAL = 2'h2;

	// reset values
	localparam logic [7:0] FMODE_RST   = 8'h0e;
	localparam logic [7:0] FOPT_RST    = 8'h00;
	localparam logic [7:0] FTYPES_RST  = 8'hff;
	localparam logic [7:0] DRV_RST     = 8'h00;
	localparam logic [7:0] PPMODE_RST  = 8'h3c;
	localparam logic [7:0] PPSHARE_RST = 8'h00;
	localparam logic [7:0] SMODE_RST   = 8'h00;

	// writable bit masks; other bits read as zero
	localparam logic [7:0] FMODE_MASK   = 8'hcf;
	localparam logic [7:0] FOPT_MASK    = 8'hff;
	localparam logic [7:0] FTYPES_MASK  = 8'hff;
	localparam logic [7:0] DRV_MASK     = 8'h5b;
	localparam logic [7:0] PPMODE_MASK  = 8'hff;
	localparam logic [7:0] PPSHARE_MASK = 8'h03;
	localparam logic [7:0] SMODE_MASK   = 8'h83;

	// field positions
	localparam int FM_ENH      = 0;
	localparam int FM_NOBURST  = 1;
	localparam int FM_IF_LO    = 2;
	localparam int DRV_PRECOMP = 6;
	localparam int PP_ITYPE    = 7;
	localparam int SM_MIDI     = 0;
	localparam int SM_HISPEED  = 1;
	localparam int SM_SHARE    = 7;

	// printer port modes
	localparam logic [2:0] PPM_PRINTER = 3'h4;
	localparam logic [2:0] PPM_SPP     = 3'h0;
	localparam logic [2:0] PPM_EPP19   = 3'h1;
	localparam logic [2:0] PPM_EPP17   = 3'h5;
	// ecp sub-modes that still behave like a plain port
	localparam logic [2:0] ECR_PRINTER = 3'h0;
	localparam logic [2:0] ECR_SPP     = 3'h1;
	localparam logic [2:0] ECR_EPP     = 3'h4;

	// pin sharing codes
	localparam logic [1:0] SHARE_SPLIT = 2'h1;
	localparam logic [1:0] SHARE_BOTH  = 2'h2;

	// pulsed interrupt width
	localparam int CLK_MHZ      = 250;
	localparam int IRQ_PULSE_NS = 16;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [3:0] {
		LDO_R_NONE, LDO_R_FMODE, LDO_R_FOPT, LDO_R_FTYPES, LDO_R_FZERO,
		LDO_R_DRV0, LDO_R_DRV1, LDO_R_PPMODE, LDO_R_PPSHARE, LDO_R_SMODE
	} ldo_reg_t;
endpackage
`default_nettype wire

// >>> verilog/ldo_option_regs.sv
// Function
// - defaults load on power-on or hard reset only
// - floppy mode bit0 selects enhanced mode two
// - floppy mode bit1 selects non-burst DMA
// - floppy mode bits3:2 select interface personality
// - drive types: A 1:0, B 3:2, default ones
// - index f3 reads zero, ignores writes
// - drive0 setup: type 1:0, rate 4:3
// - setup bit6 disables precompensation for drive
// - drive1 setup mirrors drive0 layout
// - printer mode bits2:0 select port mode
// - printer mode bits6:3 hold fifo threshold
// - type bit set: pulsed low then released
// - type bit clear: follow ack or level
// - type bit ignored in printer, spp modes
// - pin share bits1:0 route drives to pins
// - serial mode bit0 enables midi
// - serial mode bit1 enables high speed
// - serial mode bit7 shares one interrupt
// - share set: both lines assert together
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
module ldo_option_regs
	import ldo_pkg::*;
#(
	parameter int PULSE_CYC = IRQ_PULSE_CYC
) (
	input  wire logic              pclk,          // 250 MHz bus clock
	input  wire logic              presetn,       // power-on reset
	input  wire logic              hard_reset,    // synchronous hard reset
	input  wire logic              psel,          // apb select
	input  wire logic              penable,       // apb access phase
	input  wire logic              pwrite,        // apb direction
	input  wire logic [ADDR_W-1:0] paddr,         // apb byte address
	input  wire logic [31:0]       pwdata,        // apb write data
	output logic      [31:0]       prdata,        // apb read data
	output logic                   pready,        // apb ready
	output logic                   pslverr,       // unmapped address
	output logic                   enhanced_floppy_mode_two, // floppy mode
	output logic                   floppy_nonburst_dma,      // dma mode
	output logic      [1:0]        floppy_if_mode,           // personality
	output logic      [7:0]        floppy_option,            // option bits
	output logic      [1:0]        drive_a_type,             // drive A type
	output logic      [1:0]        drive_b_type,             // drive B type
	output logic      [3:0]        drive_type_spare,         // storage bits
	output logic      [1:0]        drive_kind_select0,       // drive 0 type
	output logic      [1:0]        rate_table_select0,       // drive 0 rates
	output logic      [1:0]        drive_kind_select1,       // drive 1 type
	output logic      [1:0]        rate_table_select1,       // drive 1 rates
	output logic      [1:0]        precomp_off,              // per drive
	output logic      [2:0]        pp_mode,                  // port mode
	output logic      [3:0]        pp_fifo_threshold,        // ecp threshold
	output logic                   split_drive_pins,         // drive 1 on port
	output logic                   both_drives_on_port_pins, // both on port
	output logic                   midi_enable,              // midi support
	output logic                   uart_high_speed,          // high speed
	input  wire logic              pp_ack_n,      // printer acknowledge
	input  wire logic              pp_ecp_irq,    // ecp level request
	input  wire logic [2:0]        pp_ecr_mode,   // ecp sub-mode
	output logic                   pp_irq,        // port irq level
	output logic                   pp_irq_oe,     // port irq drive enable
	input  wire logic              uart_irq_in,   // uart request
	input  wire logic              midi_irq_in,   // midi request
	output logic                   uart_irq,      // uart irq line
	output logic                   midi_irq       // midi irq line
);

	typedef struct packed {
		logic [7:0]  fmode;
		logic [7:0]  fopt;
		logic [7:0]  ftypes;
		logic [7:0]  drv0;
		logic [7:0]  drv1;
		logic [7:0]  ppmode;
		logic [7:0]  ppshare;
		logic [7:0]  smode;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic        ack_q;
		logic [7:0]  pulse;
		logic        irq;
		logic        irq_oe;
		logic        uirq;
		logic        mirq;
		logic        split;
		logic        both;
	} ldo_state_t;

	ldo_state_t st;
	ldo_state_t next_st;

	function automatic ldo_reg_t reg_sel(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		reg_sel = LDO_R_NONE;
		if (a[1:0] != 2'h0) begin
			reg_sel = LDO_R_NONE;
		end else if (a[11:10] == BANK_FLOPPY && idx == IDX_MODE) begin
			reg_sel = LDO_R_FMODE;
		end else if (a[11:10] == BANK_FLOPPY && idx == IDX_OPTION) begin
			reg_sel = LDO_R_FOPT;
		end else if (a[11:10] == BANK_FLOPPY && idx == IDX_TYPES) begin
			reg_sel = LDO_R_FTYPES;
		end else if (a[11:10] == BANK_FLOPPY && idx == IDX_ZERO) begin
			reg_sel = LDO_R_FZERO;
		end else if (a[11:10] == BANK_FLOPPY && idx == IDX_DRV0) begin
			reg_sel = LDO_R_DRV0;
		end else if (a[11:10] == BANK_FLOPPY && idx == IDX_DRV1) begin
			reg_sel = LDO_R_DRV1;
		end else if (a[11:10] == BANK_PRINT && idx == IDX_MODE) begin
			reg_sel = LDO_R_PPMODE;
		end else if (a[11:10] == BANK_PRINT && idx == IDX_OPTION) begin
			reg_sel = LDO_R_PPSHARE;
		end else if (a[11:10] == BANK_SERIAL && idx == IDX_MODE) begin
			reg_sel = LDO_R_SMODE;
		end
	endfunction

	ldo_reg_t sel;
	logic     wr_go;
	logic     setup;
	logic     ack_fall;
	logic     ecp_family;
	logic     follow_ack;
	logic     midi_req;
	logic     any_req;
	logic [7:0] rd;

	always_comb begin
		sel = reg_sel(paddr);
		setup = psel && !penable;
		// a write lands only on the edge that completes the access phase
		wr_go = psel && penable && st.ready && pwrite;
		ack_fall = st.ack_q && !pp_ack_n;
		ecp_family = pp_mode[1];
		midi_req = midi_irq_in && midi_enable;
		any_req = uart_irq_in || midi_req;

		// read mux, masks keep reserved bits at zero
		rd = 8'h00;
		case (sel)
			LDO_R_FMODE:   rd = st.fmode;
			LDO_R_FOPT:    rd = st.fopt;
			LDO_R_FTYPES:  rd = st.ftypes;
			LDO_R_FZERO:   rd = 8'h00;
			LDO_R_DRV0:    rd = st.drv0 & DRV_MASK;
			LDO_R_DRV1:    rd = st.drv1 & DRV_MASK;
			LDO_R_PPMODE:  rd = st.ppmode;
			LDO_R_PPSHARE: rd = st.ppshare;
			LDO_R_SMODE:   rd = st.smode;
			default:       rd = 8'h00;
		endcase

		next_st = st;
		next_st.ack_q = pp_ack_n;

		// no wait state: ready rises the cycle after setup, the first access cycle
		next_st.ready = setup;
		if (setup) begin
			next_st.rdata = {24'h000000, rd};
			next_st.err = (sel == LDO_R_NONE);
		end else if (st.ready) begin
			next_st.err = 1'b0;
		end

		if (wr_go) begin
			case (sel)
				LDO_R_FMODE:   next_st.fmode = pwdata[7:0] & FMODE_MASK;
				LDO_R_FOPT:    next_st.fopt = pwdata[7:0] & FOPT_MASK;
				LDO_R_FTYPES:  next_st.ftypes = pwdata[7:0] & FTYPES_MASK;
				LDO_R_DRV0:    next_st.drv0 = pwdata[7:0] & DRV_MASK;
				LDO_R_DRV1:    next_st.drv1 = pwdata[7:0] & DRV_MASK;
				LDO_R_PPMODE:  next_st.ppmode = pwdata[7:0] & PPMODE_MASK;
				LDO_R_PPSHARE: next_st.ppshare = pwdata[7:0] & PPSHARE_MASK;
				LDO_R_SMODE:   next_st.smode = pwdata[7:0] & SMODE_MASK;
				default:       next_st.fmode = st.fmode;
			endcase
		end

		// printer port interrupt shaping
		follow_ack = 1'b0;
		if (pp_mode == PPM_PRINTER || pp_mode == PPM_SPP) begin
			follow_ack = 1'b1;
		end else if (!ecp_family) begin
			follow_ack = 1'b1;
		end else if (pp_ecr_mode == ECR_PRINTER || pp_ecr_mode == ECR_SPP || pp_ecr_mode == ECR_EPP) begin
			follow_ack = 1'b1;
		end

		if (next_st.pulse != 8'h00) begin
			next_st.pulse = st.pulse - 8'h01;
		end
		if (!follow_ack || pp_mode == PPM_EPP19 || pp_mode == PPM_EPP17 || ecp_family) begin
			if (st.ppmode[PP_ITYPE] && pp_mode != PPM_PRINTER && pp_mode != PPM_SPP) begin
				// pulsed mode: drive low briefly on the ack edge, then let go
				if (ack_fall) begin
					next_st.pulse = 8'(PULSE_CYC);
				end
			end
		end
		if (st.ppmode[PP_ITYPE] && pp_mode != PPM_PRINTER && pp_mode != PPM_SPP) begin
			next_st.irq = 1'b0;
			next_st.irq_oe = (next_st.pulse != 8'h00);
		end else if (follow_ack) begin
			next_st.irq = pp_ack_n;
			next_st.irq_oe = 1'b1;
		end else begin
			next_st.irq = pp_ecp_irq;
			next_st.irq_oe = 1'b1;
		end
		if (!(st.ppmode[PP_ITYPE] && pp_mode != PPM_PRINTER && pp_mode != PPM_SPP)) begin
			next_st.pulse = 8'h00;
		end

		// shared interrupt drives both lines, even if two lines were assigned
		if (st.smode[SM_SHARE]) begin
			next_st.uirq = any_req;
			next_st.mirq = any_req;
		end else begin
			next_st.uirq = uart_irq_in;
			next_st.mirq = midi_req;
		end

		// hard reset reloads the bank; apart from power-on reset, nothing else does
		if (hard_reset) begin
			next_st.fmode = FMODE_RST;
			next_st.fopt = FOPT_RST;
			next_st.ftypes = FTYPES_RST;
			next_st.drv0 = DRV_RST;
			next_st.drv1 = DRV_RST;
			next_st.ppmode = PPMODE_RST;
			next_st.ppshare = PPSHARE_RST;
			next_st.smode = SMODE_RST;
		end

		// decoded ahead of the flop so the pin-share outputs come straight from a register
		next_st.split = (next_st.ppshare[1:0] == SHARE_SPLIT);
		next_st.both = (next_st.ppshare[1:0] == SHARE_BOTH);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.fmode <= FMODE_RST;
			st.fopt <= FOPT_RST;
			st.ftypes <= FTYPES_RST;
			st.drv0 <= DRV_RST;
			st.drv1 <= DRV_RST;
			st.ppmode <= PPMODE_RST;
			st.ppshare <= PPSHARE_RST;
			st.smode <= SMODE_RST;
			st.ack_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = st.ready;
	assign pslverr = st.err;
	assign enhanced_floppy_mode_two = st.fmode[FM_ENH];
	assign floppy_nonburst_dma = st.fmode[FM_NOBURST];
	assign floppy_if_mode = st.fmode[FM_IF_LO+1:FM_IF_LO];
	assign floppy_option = st.fopt;
	assign drive_a_type = st.ftypes[1:0];
	assign drive_b_type = st.ftypes[3:2];
	assign drive_type_spare = st.ftypes[7:4];
	assign drive_kind_select0 = st.drv0[1:0];
	assign rate_table_select0 = st.drv0[4:3];
	assign drive_kind_select1 = st.drv1[1:0];
	assign rate_table_select1 = st.drv1[4:3];
	assign precomp_off = {st.drv1[DRV_PRECOMP], st.drv0[DRV_PRECOMP]};
	assign pp_mode = st.ppmode[2:0];
	assign pp_fifo_threshold = st.ppmode[6:3];
	// code 11 is reserved and behaves as normal operation
	assign split_drive_pins = st.split;
	assign both_drives_on_port_pins = st.both;
	assign midi_enable = st.smode[SM_MIDI];
	assign uart_high_speed = st.smode[SM_HISPEED];
	assign pp_irq = st.irq;
	assign pp_irq_oe = st.irq_oe;
	assign uart_irq = st.uirq;
	assign midi_irq = st.mirq;

	// checks
	AST_HARD_RESET: assert property (@(posedge pclk) disable iff (!presetn)
		hard_reset |=> (st.fmode == FMODE_RST && st.ppmode == PPMODE_RST && st.ftypes == FTYPES_RST))
		else $error("hard reset did not reload defaults");
	AST_FMODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_FMODE && !hard_reset) |=>
		(enhanced_floppy_mode_two == $past(pwdata[0]) && floppy_if_mode == $past(pwdata[3:2])))
		else $error("floppy mode write not reflected");
	AST_DMA_MODE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_FMODE && !hard_reset) |=> floppy_nonburst_dma == $past(pwdata[1]))
		else $error("dma mode bit wrong");
	AST_TYPES: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_FTYPES && !hard_reset) |=> drive_b_type == $past(pwdata[3:2]))
		else $error("drive B type not stored");
	AST_ZERO_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && sel == LDO_R_FZERO) |=> (pready && prdata == 32'h00000000))
		else $error("index f3 not zero");
	AST_DRV_RO: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && (sel == LDO_R_DRV0 || sel == LDO_R_DRV1)) |=>
		(prdata[7] == 1'b0 && prdata[5] == 1'b0 && prdata[2] == 1'b0))
		else $error("drive setup read-only bits set");
	AST_PRECOMP: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_DRV1 && !hard_reset) |=> precomp_off[1] == $past(pwdata[6]))
		else $error("drive 1 precompensation bit wrong");
	AST_PP_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		(ack_fall && st.ppmode[PP_ITYPE] && pp_mode != PPM_PRINTER && pp_mode != PPM_SPP && !hard_reset && !wr_go)
		|=> (pp_irq_oe && !pp_irq))
		else $error("pulsed interrupt not driven low");
	AST_PP_PRINTER: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && pp_mode == PPM_PRINTER) |=> (pp_irq_oe && pp_irq == $past(pp_ack_n)))
		else $error("printer mode interrupt must follow ack");
	AST_SHARE: assert property (@(posedge pclk) disable iff (!presetn)
		(st.smode[SM_SHARE] && (uart_irq_in || midi_req)) |=> (uart_irq && midi_irq))
		else $error("shared interrupt not on both lines");
	AST_PIN_SHARE_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && sel == LDO_R_PPSHARE) |=> prdata[7:2] == 6'h00)
		else $error("reserved share bits not zero");
	AST_SERIAL: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_SMODE && !hard_reset) |=>
		(uart_high_speed == $past(pwdata[1]) && midi_enable == $past(pwdata[0])))
		else $error("serial mode write not reflected");
	AST_PP_MODE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_PPMODE && !hard_reset) |=> pp_mode == $past(pwdata[2:0]))
		else $error("printer port mode not stored");
	AST_FIFO_THRESH: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_PPMODE && !hard_reset) |=> pp_fifo_threshold == $past(pwdata[6:3]))
		else $error("fifo threshold not stored");
	AST_PULSE_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
		(st.ppmode[PP_ITYPE] && pp_mode != PPM_PRINTER && pp_mode != PPM_SPP && st.pulse == 8'h01 && !ack_fall)
		|=> !pp_irq_oe)
		else $error("pulsed interrupt not released");
	AST_EPP_ACK: assert property (@(posedge pclk) disable iff (!presetn)
		(!st.ppmode[PP_ITYPE] && (pp_mode == PPM_EPP19 || pp_mode == PPM_EPP17))
		|=> (pp_irq_oe && pp_irq == $past(pp_ack_n)))
		else $error("epp interrupt must follow ack");
	AST_ECP_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		(!st.ppmode[PP_ITYPE] && pp_mode[1] &&
		pp_ecr_mode != ECR_PRINTER && pp_ecr_mode != ECR_SPP && pp_ecr_mode != ECR_EPP)
		|=> (pp_irq_oe && pp_irq == $past(pp_ecp_irq)))
		else $error("ecp level interrupt wrong");
	AST_SPP_ACK: assert property (@(posedge pclk) disable iff (!presetn)
		(pp_mode == PPM_SPP) |=> (pp_irq_oe && pp_irq == $past(pp_ack_n)))
		else $error("spp mode interrupt must follow ack");
	AST_SHARE_PINS: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_PPSHARE && !hard_reset) |=>
		(split_drive_pins == ($past(pwdata[1:0]) == SHARE_SPLIT) &&
		both_drives_on_port_pins == ($past(pwdata[1:0]) == SHARE_BOTH)))
		else $error("pin share decode wrong");
	AST_MIDI_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		(!st.smode[SM_SHARE] && !midi_enable) |=> !midi_irq)
		else $error("midi interrupt while midi disabled");
	AST_SPLIT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && !st.smode[SM_SHARE]) |=> uart_irq == $past(uart_irq_in))
		else $error("separate uart interrupt wrong");
	AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && sel == LDO_R_NONE) |=> (pready && pslverr && prdata == 32'h00000000))
		else $error("unmapped access not refused");
	AST_DRV0: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_DRV0 && !hard_reset) |=>
		(drive_kind_select0 == $past(pwdata[1:0]) && rate_table_select0 == $past(pwdata[4:3])))
		else $error("drive 0 setup fields not stored");
	AST_DRV1: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_DRV1 && !hard_reset) |=>
		(drive_kind_select1 == $past(pwdata[1:0]) && rate_table_select1 == $past(pwdata[4:3])))
		else $error("drive 1 setup fields not stored");
	AST_ZERO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_go && sel == LDO_R_FZERO && !hard_reset) |=>
		(st.fmode == $past(st.fmode) && st.drv0 == $past(st.drv0)))
		else $error("write to index f3 changed a register");

endmodule
`default_nettype wire

// >>> test/ldo_option_regs_tb.sv
`default_nettype none
module tb
	import ldo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// short pulse keeps the pulsed-interrupt test quick
	localparam int PC = 3;

	logic              pclk, presetn, hard_reset, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, err;
	logic              enhanced_floppy_mode_two, floppy_nonburst_dma, split_drive_pins, both_drives_on_port_pins;
	logic              midi_enable, uart_high_speed, pp_ack_n, pp_ecp_irq, pp_irq, pp_irq_oe;
	logic              uart_irq_in, midi_irq_in, uart_irq, midi_irq;
	logic [1:0]        floppy_if_mode, drive_a_type, drive_b_type, drive_kind_select0, rate_table_select0;
	logic [1:0]        drive_kind_select1, rate_table_select1, precomp_off;
	logic [2:0]        pp_mode, pp_ecr_mode;
	logic [3:0]        drive_type_spare, pp_fifo_threshold;
	logic [7:0]        floppy_option;
	int                failures, check_count, n;

	ldo_option_regs #(.PULSE_CYC(PC)) dut (
		.pclk, .presetn, .hard_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.enhanced_floppy_mode_two, .floppy_nonburst_dma, .floppy_if_mode, .floppy_option, .drive_a_type,
		.drive_b_type, .drive_type_spare, .drive_kind_select0, .rate_table_select0, .drive_kind_select1,
		.rate_table_select1, .precomp_off, .pp_mode, .pp_fifo_threshold, .split_drive_pins,
		.both_drives_on_port_pins, .midi_enable, .uart_high_speed, .pp_ack_n, .pp_ecp_irq, .pp_ecr_mode,
		.pp_irq, .pp_irq_oe, .uart_irq_in, .midi_irq_in, .uart_irq, .midi_irq
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic final_report();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [ADDR_W-1:0] ad(input logic [1:0] b, input logic [7:0] i);
		return {b, i, 2'b00};
	endfunction

	// one idle cycle between transfers so no strobe is driven twice in a step
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			final_report();
		end
	endtask

	task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(nm, {24'h000000, e}, rd);
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic defaults_check();
		rdc("fmode", ad(BANK_FLOPPY, IDX_MODE), 8'h0e);
		rdc("fopt", ad(BANK_FLOPPY, IDX_OPTION), 8'h00);
		rdc("ftypes", ad(BANK_FLOPPY, IDX_TYPES), 8'hff);
		rdc("fzero", ad(BANK_FLOPPY, IDX_ZERO), 8'h00);
		rdc("drv0", ad(BANK_FLOPPY, IDX_DRV0), 8'h00);
		rdc("drv1", ad(BANK_FLOPPY, IDX_DRV1), 8'h00);
		rdc("ppmode", ad(BANK_PRINT, IDX_MODE), 8'h3c);
		rdc("ppshare", ad(BANK_PRINT, IDX_OPTION), 8'h00);
		rdc("smode", ad(BANK_SERIAL, IDX_MODE), 8'h00);
	endtask

	initial begin
		{presetn, hard_reset, psel, penable, pwrite, pp_ecp_irq, uart_irq_in, midi_irq_in} = '0;
		{paddr, pwdata, pp_ecr_mode, failures, check_count} = '0;
		pp_ack_n = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		defaults_check();
		$display("test defaults done");

		apb(1'b1, ad(BANK_FLOPPY, IDX_MODE), 8'hf5);
		apb(1'b1, ad(BANK_FLOPPY, IDX_OPTION), 8'ha5);
		apb(1'b1, ad(BANK_FLOPPY, IDX_TYPES), 8'h9c);
		apb(1'b1, ad(BANK_FLOPPY, IDX_ZERO), 8'hff);
		apb(1'b1, ad(BANK_FLOPPY, IDX_DRV0), 8'hff);
		apb(1'b1, ad(BANK_FLOPPY, IDX_DRV1), 8'h4a);
		apb(1'b1, ad(BANK_SERIAL, IDX_MODE), 8'hff);
		rdc("fmode", ad(BANK_FLOPPY, IDX_MODE), 8'hc5);
		rdc("fopt", ad(BANK_FLOPPY, IDX_OPTION), 8'ha5);
		rdc("ftypes", ad(BANK_FLOPPY, IDX_TYPES), 8'h9c);
		rdc("fzero", ad(BANK_FLOPPY, IDX_ZERO), 8'h00);
		rdc("drv0", ad(BANK_FLOPPY, IDX_DRV0), 8'h5b);
		rdc("drv1", ad(BANK_FLOPPY, IDX_DRV1), 8'h4a);
		rdc("smode", ad(BANK_SERIAL, IDX_MODE), 8'h83);
		@(negedge pclk);
		chk("enh", 1'b1, enhanced_floppy_mode_two);
		chk("nonburst", 1'b0, floppy_nonburst_dma);
		chk("ifmode", 2'h1, floppy_if_mode);
		chk("option", 8'ha5, floppy_option);
		chk("types", 8'h9c, {drive_type_spare, drive_b_type, drive_a_type});
		chk("drv0f", 4'hf, {rate_table_select0, drive_kind_select0});
		chk("drv1f", 4'h6, {rate_table_select1, drive_kind_select1});
		chk("precomp", 2'h3, precomp_off);
		chk("midi_hs", 2'h3, {midi_enable, uart_high_speed});
		chk("ppmode", 7'h3c, {pp_fifo_threshold, pp_mode});
		$display("test write readback done");

		apb(1'b1, ad(2'h3, IDX_MODE), 8'hff);
		chk("slverr_w", 1'b1, err);
		apb(1'b0, ad(2'h3, IDX_MODE), 8'h00);
		chk("slverr_r", 1'b1, err);
		chk("unmapped_rd", 32'h0, rd);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ad(BANK_PRINT, IDX_OPTION), 8'(c) | 8'hfc);
			rdc("ppshare", ad(BANK_PRINT, IDX_OPTION), 8'(c));
			chk("pinshare", {both_drives_on_port_pins, split_drive_pins}, {c == 2, c == 1});
		end
		$display("test refusal and pin share done");

		@(posedge pclk);
		hard_reset <= 1'b1;
		@(posedge pclk);
		hard_reset <= 1'b0;
		defaults_check();
		$display("test hard reset done");

		apb(1'b1, ad(BANK_SERIAL, IDX_MODE), 8'h81);
		@(posedge pclk);
		midi_irq_in <= 1'b1;
		cyc(2);
		chk("share_irq", 2'h3, {uart_irq, midi_irq});
		apb(1'b1, ad(BANK_SERIAL, IDX_MODE), 8'h01);
		cyc(2);
		chk("split_irq", 2'h1, {uart_irq, midi_irq});
		@(posedge pclk);
		midi_irq_in <= 1'b0;
		uart_irq_in <= 1'b1;
		cyc(2);
		chk("uart_irq", 2'h2, {uart_irq, midi_irq});
		$display("test serial interrupt done");

		apb(1'b1, ad(BANK_PRINT, IDX_MODE), 8'h84);
		cyc(2);
		chk("prn_hi", 2'h3, {pp_irq, pp_irq_oe});
		@(posedge pclk);
		pp_ack_n <= 1'b0;
		cyc(2);
		chk("prn_lo", 2'h1, {pp_irq, pp_irq_oe});
		apb(1'b1, ad(BANK_PRINT, IDX_MODE), 8'h02);
		@(posedge pclk);
		pp_ecr_mode <= 3'h2;
		pp_ecp_irq <= 1'b1;
		cyc(2);
		chk("ecp_level", 2'h3, {pp_irq, pp_irq_oe});
		@(posedge pclk);
		pp_ecr_mode <= ECR_PRINTER;
		cyc(2);
		chk("ecp_ack", 2'h1, {pp_irq, pp_irq_oe});
		apb(1'b1, ad(BANK_PRINT, IDX_MODE), 8'h80);
		cyc(2);
		chk("spp_type_ignored", 2'h1, {pp_irq, pp_irq_oe});
		apb(1'b1, ad(BANK_PRINT, IDX_MODE), 8'h01);
		cyc(2);
		chk("epp_ack", 2'h1, {pp_irq, pp_irq_oe});
		apb(1'b1, ad(BANK_PRINT, IDX_MODE), 8'h82);
		@(posedge pclk);
		pp_ack_n <= 1'b1;
		cyc(3);
		@(posedge pclk);
		pp_ack_n <= 1'b0;
		n = 0;
		repeat (12) begin
			@(negedge pclk);
			n += int'(pp_irq_oe === 1'b1 && pp_irq === 1'b0);
		end
		chk("pulse_len", PC, n);
		chk("released", 1'b0, pp_irq_oe);
		$display("test port interrupt done");
		final_report();
	end

	initial begin
		#400000;
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
